// ---- rtl/chp_buf2.sv ----
// Two-entry buffer with registered head and valid/ready on both sides.
`timescale 1ns/1ns
module chp_buf2 #(
   parameter int W = 8
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   logic tail_v;
   logic [W-1:0] tail;
   logic push;
   logic pop;

   assign in_ready_o = ~tail_v;
   assign push = in_valid_i & ~tail_v;
   assign pop = out_valid_o & out_ready_i;

   // The head is the output register, so the drain side sees no logic after it.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
         tail_v <= 1'b0;
         tail <= '0;
      end else if (!out_valid_o || pop) begin
         if (tail_v) begin
            out_data_o <= tail;
            out_valid_o <= 1'b1;
            tail_v <= push;
            if (push) begin
               tail <= in_data_i;
            end
         end else begin
            out_valid_o <= push;
            if (push) begin
               out_data_o <= in_data_i;
            end
         end
      end else if (push) begin
         tail <= in_data_i;
         tail_v <= 1'b1;
      end
   end
endmodule : chp_buf2

// ---- rtl/chp_config_host_port.sv ----
// Configuration loading and processor port handshake of the device.
`timescale 1ns/1ns
module chp_config_host_port
   import chp_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic power_ok_i,
   input wire logic [3:0] mode_pins_i,
   input wire logic clear_hold_i,
   output logic clear_hold_o,
   output logic clear_hold_oe_n_o,
   input wire logic select_low_active_n_i,
   input wire logic select_high_active_i,
   input wire logic read_strobe_n_i,
   input wire logic write_strobe_n_i,
   input wire logic [31:0] data_i,
   output logic [31:0] data_o,
   output logic [31:0] data_oe_n_o,
   input wire logic [17:0] host_address_lsbs_i,
   input wire logic burst_marker_n_i,
   input wire logic [1:0] transfer_size_code_i,
   output logic host_transfer_ack_n_o,
   output logic ready_busy_o,
   output logic ready_busy_oe_n_o,
   output logic high_while_loading_o,
   output logic low_while_loading_o,
   output logic [3:0] cfg_mode_o,
   output logic [7:0] cfg_byte_o,
   output logic cfg_byte_valid_o,
   input wire logic cfg_byte_ready_i,
   input wire logic config_done_i,
   output chp_proc_req_t proc_req_o,
   output logic proc_req_valid_o,
   input wire logic [31:0] proc_rdata_i
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [17:0] sync_v;
   logic s_pwr;
   logic s_init;
   logic [3:0] s_mode;
   logic s_sel_n;
   logic s_sel;
   logic s_rd_n;
   logic s_wr_n;
   logic [7:0] s_data;

   chp_sync #(
      .W(18),
      .RST(SYNC_RST)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .async_i({power_ok_i, clear_hold_i, mode_pins_i, select_low_active_n_i,
                select_high_active_i, read_strobe_n_i, write_strobe_n_i, data_i[7:0]}),
      .sync_o(sync_v)
   );

   assign s_pwr = sync_v[17];
   assign s_init = sync_v[16];
   assign s_mode = sync_v[15:12];
   assign s_sel_n = sync_v[11];
   assign s_sel = sync_v[10];
   assign s_rd_n = sync_v[9];
   assign s_wr_n = sync_v[8];
   assign s_data = sync_v[7:0];

   // ************************************************************
   // Configuration sequence
   // ************************************************************
   chp_state_t state;
   logic [7:0] clr_cnt;
   logic init_prev;
   logic loading;
   logic cfg_over;

   assign loading = (state == ST_LOAD);
   assign cfg_over = (state == ST_DONE) | (loading & config_done_i);

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= ST_POWER;
         clr_cnt <= 8'h00;
      end else begin
         case (state)
            ST_POWER: begin
               clr_cnt <= 8'h00;
               if (s_pwr) begin
                  state <= ST_CLEAR;
               end
            end
            ST_CLEAR: begin
               clr_cnt <= clr_cnt + 8'h01;
               if (clr_cnt == 8'(CLEAR_CYCLES - 1)) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // An outside party holding the pin low keeps the device here.
               if (s_init && !init_prev) begin
                  state <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               if (config_done_i) begin
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               state <= ST_DONE;
            end
            default: begin
               state <= ST_POWER;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         init_prev <= 1'b0;
         cfg_mode_o <= 4'h0;
      end else begin
         init_prev <= s_init;
         if (state == ST_WAIT && s_init && !init_prev) begin
            cfg_mode_o <= s_mode;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         clear_hold_o <= 1'b0;
         clear_hold_oe_n_o <= 1'b0;
         high_while_loading_o <= 1'b1;
         low_while_loading_o <= 1'b0;
      end else begin
         clear_hold_o <= 1'b0;
         clear_hold_oe_n_o <= ~(state == ST_POWER || state == ST_CLEAR);
         high_while_loading_o <= ~cfg_over;
         low_while_loading_o <= cfg_over;
      end
   end

   // ************************************************************
   // Async peripheral and master parallel byte paths
   // ************************************************************
   logic mode_async;
   logic mode_master;
   logic mode_proc;
   logic sel_async;
   logic wr_prev;
   logic push_async;
   logic rd_active;
   logic [3:0] mcnt;
   logic push_master;
   logic push_proc;
   logic buf_in_ready;
   logic buf_in_valid;
   logic [7:0] buf_in_data;

   assign mode_async = (cfg_mode_o == MODE_ASYNC);
   assign mode_master = (cfg_mode_o == MODE_MASTER);
   assign mode_proc = (cfg_mode_o == MODE_PROC);
   assign sel_async = ~s_sel_n & s_sel;
   assign push_async = mode_async & loading & sel_async & wr_prev & ~s_wr_n;
   // A write strobe held low blocks the status read.
   assign rd_active = mode_async & loading & sel_async & ~s_rd_n & s_wr_n;
   assign push_master = mode_master & loading & (mcnt == 4'h1);

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_prev <= 1'b1;
      end else begin
         wr_prev <= s_wr_n;
      end
   end

   // The fetch starts only with room in the buffer, so the fetched byte always fits.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mcnt <= 4'h0;
      end else if (!(mode_master && loading && !config_done_i)) begin
         mcnt <= 4'h0;
      end else if (mcnt != 4'h0) begin
         mcnt <= mcnt - 4'h1;
      end else if (buf_in_ready) begin
         mcnt <= 4'(MEM_READ_CYCLES);
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ready_busy_o <= 1'b0;
         ready_busy_oe_n_o <= 1'b0;
      end else begin
         ready_busy_oe_n_o <= cfg_over;
         if (mode_master) begin
            ready_busy_o <= loading & (mcnt != 4'h0);
         end else begin
            ready_busy_o <= loading & buf_in_ready;
         end
      end
   end

   assign buf_in_valid = push_async | push_master | push_proc;
   assign buf_in_data = mode_proc ? proc_req_o.wdata[7:0] : s_data;

   chp_buf2 #(
      .W(8)
   ) u_buf (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .in_valid_i(buf_in_valid),
      .in_ready_o(buf_in_ready),
      .in_data_i(buf_in_data),
      .out_valid_o(cfg_byte_valid_o),
      .out_ready_i(cfg_byte_ready_i),
      .out_data_o(cfg_byte_o)
   );

   // ************************************************************
   // Processor port
   // ************************************************************
   // Pins here are synchronous to the system clock, so they are sampled directly.
   logic proc_sel;
   logic proc_accept;
   logic pend;
   logic pend_load;
   logic proc_done;
   logic [3:0] lanes;
   logic [31:0] rdata_q;

   assign proc_sel = ~select_low_active_n_i & select_high_active_i;
   assign proc_accept = mode_proc & proc_sel & ~read_strobe_n_i & ~pend & (loading | (state == ST_DONE));
   assign push_proc = pend & pend_load & buf_in_ready;
   assign proc_done = pend & (pend_load ? buf_in_ready : ~proc_req_valid_o);

   always_comb begin
      case (transfer_size_code_i)
         TSZ_BYTE: lanes = 4'h1 << host_address_lsbs_i[1:0];
         TSZ_HALF: lanes = host_address_lsbs_i[1] ? 4'hC : 4'h3;
         TSZ_WORD: lanes = 4'hF;
         default: lanes = 4'h0;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pend <= 1'b0;
         pend_load <= 1'b0;
         proc_req_o <= '0;
         proc_req_valid_o <= 1'b0;
         host_transfer_ack_n_o <= 1'b1;
      end else begin
         proc_req_valid_o <= 1'b0;
         host_transfer_ack_n_o <= 1'b1;
         if (proc_accept) begin
            pend <= 1'b1;
            pend_load <= loading & ~write_strobe_n_i;
            proc_req_valid_o <= ~(loading & ~write_strobe_n_i);
            proc_req_o.write <= ~write_strobe_n_i;
            proc_req_o.burst <= ~burst_marker_n_i;
            proc_req_o.size <= transfer_size_code_i;
            proc_req_o.lanes <= lanes;
            proc_req_o.addr <= host_address_lsbs_i;
            proc_req_o.wdata <= data_i;
         end else if (proc_done) begin
            pend <= 1'b0;
            pend_load <= 1'b0;
            host_transfer_ack_n_o <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Data bus drive
   // ************************************************************
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_q <= 32'h00000000;
         data_o <= 32'h00000000;
         data_oe_n_o <= 32'hFFFFFFFF;
      end else begin
         data_oe_n_o <= 32'hFFFFFFFF;
         if (proc_req_valid_o) begin
            rdata_q <= proc_rdata_i;
         end
         if (rd_active) begin
            data_o[7:3] <= {buf_in_ready, cfg_over, cfg_byte_valid_o, s_init, mode_async};
            data_oe_n_o[7:3] <= 5'h00;
         end else if (proc_done && !pend_load && !proc_req_o.write) begin
            data_o <= rdata_q;
            data_oe_n_o <= 32'h00000000;
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);

   property p_progress_pair;
      high_while_loading_o != low_while_loading_o;
   endproperty
   a_progress_pair: assert property (p_progress_pair) else $error("Progress outputs disagree.");

   property p_release_together;
      (loading && config_done_i) |=> (!high_while_loading_o && ready_busy_oe_n_o);
   endproperty
   a_release_together: assert property (p_release_together) else $error("Release not simultaneous.");

   property p_clear_drive;
      (state == ST_CLEAR) |=> !clear_hold_oe_n_o;
   endproperty
   a_clear_drive: assert property (p_clear_drive) else $error("Clear pin not driven low.");

   property p_hold_wait;
      (state == ST_WAIT && !s_init) |=> (state == ST_WAIT);
   endproperty
   a_hold_wait: assert property (p_hold_wait) else $error("Left wait while held.");

   property p_mode_latch;
      (state == ST_WAIT && s_init && !init_prev) |=> (cfg_mode_o == $past(s_mode)) && loading;
   endproperty
   a_mode_latch: assert property (p_mode_latch) else $error("Mode not latched.");

   property p_write_wins;
      (mode_async && !s_wr_n) |=> (data_oe_n_o[7:3] == 5'h1F);
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("Status driven during write.");

   property p_status_ready;
      rd_active |=> (!data_oe_n_o[7] && data_o[7] == $past(buf_in_ready));
   endproperty
   a_status_ready: assert property (p_status_ready) else $error("Status bit 7 wrong.");

   property p_ack_time;
      (proc_accept && !(loading && !write_strobe_n_i)) |-> ##3 !host_transfer_ack_n_o;
   endproperty
   a_ack_time: assert property (p_ack_time) else $error("Ack not three cycles after strobe.");

   property p_burst_flag;
      proc_accept |=> (proc_req_o.burst == !$past(burst_marker_n_i));
   endproperty
   a_burst_flag: assert property (p_burst_flag) else $error("Burst flag wrong.");

   property p_word_lanes;
      (proc_req_valid_o && proc_req_o.size == TSZ_WORD) |-> (proc_req_o.lanes == 4'hF);
   endproperty
   a_word_lanes: assert property (p_word_lanes) else $error("Word size lanes wrong.");

   property p_ready_level;
      (mode_async && loading && !config_done_i) |=> (ready_busy_o == $past(buf_in_ready));
   endproperty
   a_ready_level: assert property (p_ready_level) else $error("Ready level wrong.");
endmodule : chp_config_host_port

// ---- rtl/chp_pkg.sv ----
// Constants, types and the behaviour summary of the configuration host port.
// ************************************************************
// How it works
// - In async peripheral loading, ready is high when another byte fits, else low.
// - A selected async peripheral read shows the same ready status on data bit 7.
// - In master parallel loading, the ready pin strobes the external memory to fetch bytes.
// - The high progress output stays high until configuration completes.
// - The low progress output stays low until configuration completes.
// - The clear/hold pin is pulled low during power settling and memory clearing.
// - While clear/hold is held low externally, the device waits and never starts loading.
// - Selected only while the low select is low and the high select is high.
// - Async peripheral read strobe low turns data bits 7 to 3 into status outputs.
// - With read and write strobes both low, the write acts and the read is ignored.
// - The status line is high for ready and low for busy.
// - An async peripheral write strobe captures the byte on data bits 7 to 0.
// - On the processor port the read strobe pin is the transfer strobe.
// - Direction line high reads from the device, low writes into it.
// - The device decodes only the eighteen least significant host address bits.
// - Burst marker low marks a burst beat, high a single transfer.
// - After configuration the ready/busy pin is released to user control.
// - Mode pins are latched at the rising edge of the clear/hold pin.
// - The transfer acknowledge goes low when write data is taken or read data is given.
// - Size code 01 is a byte, 10 a half-word, 00 a word.
// - Processor port pins are sampled and driven on the rising host bus clock edge.
// ************************************************************
package chp_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CLEAR_TIME_NS = 200;
   localparam int CLEAR_CYCLES = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MEM_READ_NS = 120;
   localparam int MEM_READ_CYCLES = (MEM_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] MODE_MASTER = 4'h4;
   localparam logic [3:0] MODE_ASYNC = 4'h5;
   localparam logic [3:0] MODE_PROC = 4'h7;
   localparam logic [1:0] TSZ_WORD = 2'h0;
   localparam logic [1:0] TSZ_BYTE = 2'h1;
   localparam logic [1:0] TSZ_HALF = 2'h2;
   localparam logic [17:0] SYNC_RST = 18'h00B00;
   typedef struct packed {
      logic write;
      logic burst;
      logic [1:0] size;
      logic [3:0] lanes;
      logic [17:0] addr;
      logic [31:0] wdata;
   } chp_proc_req_t;
   typedef enum logic [4:0] {
      ST_POWER = 5'h01,
      ST_CLEAR = 5'h02,
      ST_WAIT = 5'h04,
      ST_LOAD = 5'h08,
      ST_DONE = 5'h10
   } chp_state_t;
endpackage : chp_pkg

// ---- rtl/chp_sync.sv ----
// Three-stage input synchroniser that passes a change once two stages agree.
`timescale 1ns/1ns
module chp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // A bit whose last two stages disagree keeps its old value, so glitches are dropped.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1 <= RST;
         s2 <= RST;
         s3 <= RST;
         sync_o <= RST;
      end else begin
         s1 <= async_i;
         s2 <= s1;
         s3 <= s2;
         sync_o <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & sync_o);
      end
   end
endmodule : chp_sync

// ---- verification/chp_config_host_port_tb.sv ----
// Self-checking bench for the configuration host port.
`timescale 1ns/1ns
module chp_config_host_port_tb
   import chp_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic power_ok_i = 1'b0;
   logic [3:0] mode_pins_i = 4'h0;
   logic cfg_byte_ready_i = 1'b0;
   logic config_done_i = 1'b0;
   logic ext_hold = 1'b1;
   logic [31:0] proc_rdata_i = 32'hC0DE1230;
   logic clear_hold_i, clear_hold_o, clear_hold_oe_n_o, select_low_active_n_i, select_high_active_i;
   logic read_strobe_n_i, write_strobe_n_i, burst_marker_n_i, host_transfer_ack_n_o, ready_busy_o;
   logic ready_busy_oe_n_o, high_while_loading_o, low_while_loading_o, cfg_byte_valid_o, proc_req_valid_o;
   logic [31:0] data_i, data_o, data_oe_n_o, rd;
   logic [17:0] host_address_lsbs_i;
   logic [1:0] transfer_size_code_i;
   logic [3:0] cfg_mode_o;
   logic [7:0] cfg_byte_o, st;
   logic [4:0] oe;
   logic ok;
   chp_proc_req_t proc_req_o, req;
   logic [1:0] szs [3] = '{TSZ_BYTE, TSZ_HALF, TSZ_WORD};
   // Byte lanes expected for the three reads, whose addresses end in 11, 10 and 01.
   logic [3:0] lns [3] = '{4'h8, 4'hC, 4'hF};
   logic [7:0] got [$];
   int err_total = 0;
   int compares = 0;
   int n;
   always #5 clk_sys_i = ~clk_sys_i;
   chp_config_host_port dut (
      .clk_sys_i, .resetn_i, .power_ok_i, .mode_pins_i, .clear_hold_i, .clear_hold_o, .clear_hold_oe_n_o,
      .select_low_active_n_i, .select_high_active_i, .read_strobe_n_i, .write_strobe_n_i, .data_i, .data_o,
      .data_oe_n_o, .host_address_lsbs_i, .burst_marker_n_i, .transfer_size_code_i, .host_transfer_ack_n_o,
      .ready_busy_o, .ready_busy_oe_n_o, .high_while_loading_o, .low_while_loading_o, .cfg_mode_o, .cfg_byte_o,
      .cfg_byte_valid_o, .cfg_byte_ready_i, .config_done_i, .proc_req_o, .proc_req_valid_o, .proc_rdata_i
   );
   chp_host_model hm (
      .clk_sys_i, .ext_hold_i(ext_hold), .hold_i(clear_hold_o), .hold_oe_n_i(clear_hold_oe_n_o),
      .bus_i(data_o), .bus_oe_n_i(data_oe_n_o), .ready_i(ready_busy_o), .ack_n_i(host_transfer_ack_n_o),
      .hold_wire_o(clear_hold_i), .bus_o(data_i), .sel_n_o(select_low_active_n_i), .sel_o(select_high_active_i),
      .rd_n_o(read_strobe_n_i), .wr_n_o(write_strobe_n_i), .addr_o(host_address_lsbs_i),
      .burst_n_o(burst_marker_n_i), .tsz_o(transfer_size_code_i)
   );
   always @(posedge clk_sys_i) begin
      if (cfg_byte_valid_o && cfg_byte_ready_i) begin
         got.push_back(cfg_byte_o);
      end
      if (proc_req_valid_o) begin
         req <= proc_req_o;
      end
   end
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input logic [31:0] act, input logic [31:0] exp);
      compares++;
      if (act !== exp) begin
         err_total++;
         $display("[ERR] %0t: got %h expected %h", $time, act, exp);
      end
   endtask : chk
   task automatic results();
      $display("compares %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   // The whole start-up repeats for each mode, since the mode is latched only once per reset.
   task automatic boot(input logic [3:0] m, input logic hold);
      resetn_i <= 1'b0;
      power_ok_i <= 1'b0;
      config_done_i <= 1'b0;
      mode_pins_i <= m;
      ext_hold <= hold;
      repeat (10) @(posedge clk_sys_i);
      got.delete();
      chk(clear_hold_oe_n_o, 1'b0);
      chk(clear_hold_o, 1'b0);
      chk(high_while_loading_o, 1'b1);
      chk(low_while_loading_o, 1'b0);
      chk(host_transfer_ack_n_o, 1'b1);
      resetn_i <= 1'b1;
      power_ok_i <= 1'b1;
      repeat (40) @(posedge clk_sys_i);
      chk(clear_hold_oe_n_o, 1'b1);
   endtask : boot
   initial begin
      #200000;
      err_total++;
      results();
   end
   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      boot(MODE_ASYNC, 1'b1);
      chk(cfg_mode_o, 4'h0);
      ext_hold <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
      chk(cfg_mode_o, MODE_ASYNC);
      chk(ready_busy_o, 1'b1);
      hm.wr_byte(8'h3C, 1'b0, 1'b0, oe);
      hm.wr_byte(8'hA5, 1'b1, 1'b0, oe);
      hm.wr_byte(8'h5A, 1'b1, 1'b1, oe);
      chk(oe, 5'h1F);
      chk(ready_busy_o, 1'b0);
      hm.rd_status(st, oe);
      chk(oe, 5'h00);
      chk(st[7:3], 5'h07);
      cfg_byte_ready_i <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      chk(got.size(), 2);
      chk({got[0], got[1]}, 16'hA55A);
      chk(ready_busy_o, 1'b1);
      hm.rd_status(st, oe);
      chk(st[7:3], 5'h13);
      config_done_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      chk({high_while_loading_o, low_while_loading_o, ready_busy_oe_n_o}, 3'h3);
      boot(MODE_PROC, 1'b0);
      chk(cfg_mode_o, MODE_PROC);
      for (int i = 0; i < 3; i++) begin
         proc_rdata_i <= 32'hC0DE1230 + i;
         hm.xfer(1'b1, 18'(18'h3FFFF - i), szs[i], i[0], 32'h0, rd, ok);
         chk(ok, 1'b1);
         chk(rd, 32'hC0DE1230 + i);
         chk({req.write, req.burst, req.size, req.lanes, req.addr}, {1'b0, i[0], szs[i], lns[i], 18'(18'h3FFFF - i)});
      end
      hm.xfer(1'b0, 18'h00012, TSZ_BYTE, 1'b0, 32'h000000E7, rd, ok);
      chk(ok, 1'b1);
      // The byte reaches the collector only on the edge at which the task returns, so let it settle.
      repeat (2) @(posedge clk_sys_i);
      chk(got.size() > 0 ? got[$] : 8'h00, 8'hE7);
      config_done_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      hm.xfer(1'b0, 18'h00012, TSZ_WORD, 1'b1, 32'h89ABCDEF, rd, ok);
      chk(ok, 1'b1);
      chk({req.write, req.burst}, 2'h3);
      chk(req.wdata, 32'h89ABCDEF);
      boot(MODE_MASTER, 1'b0);
      n = 0;
      while (got.size() == 0 && n < 60) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk(got.size() > 0 ? got[0] : 8'h00, 8'hFF);
      n = 0;
      while (ready_busy_o !== 1'b1 && n < 60) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk(ready_busy_o, 1'b1);
      results();
   end
endmodule : chp_config_host_port_tb

// ---- verification/chp_host_model.sv ----
// Behavioural host processor that drives the configuration port pins.
`timescale 1ns/1ns
module chp_host_model (
   input wire logic clk_sys_i,
   input wire logic ext_hold_i,
   input wire logic hold_i,
   input wire logic hold_oe_n_i,
   input wire logic [31:0] bus_i,
   input wire logic [31:0] bus_oe_n_i,
   input wire logic ready_i,
   input wire logic ack_n_i,
   output logic hold_wire_o,
   output logic [31:0] bus_o,
   output logic sel_n_o,
   output logic sel_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic [17:0] addr_o,
   output logic burst_n_o,
   output logic [1:0] tsz_o
);
   logic host_oe = 1'b0;
   logic [31:0] host_data = 32'h0;
   logic [23:0] last_hi = 24'h0;
   logic [31:0] idle_v;
   initial begin
      sel_n_o = 1'b1;
      sel_o = 1'b0;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      addr_o = 18'h0;
      burst_n_o = 1'b1;
      tsz_o = 2'h0;
   end
   // The wire has a pull-up, so it reads low only while some party pulls it.
   assign hold_wire_o = !((!hold_oe_n_i && !hold_i) || ext_hold_i);
   // Released upper lanes show the inverse of their last value so stale data cannot pass.
   assign idle_v = {~last_hi, 8'hFF};
   always_comb begin
      for (int b = 0; b < 32; b++) begin
         bus_o[b] = !bus_oe_n_i[b] ? bus_i[b] : (host_oe ? host_data[b] : idle_v[b]);
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (host_oe) begin
         last_hi <= host_data[31:8];
      end
   end
   task automatic wr_byte(input logic [7:0] b, input logic sel_ok, input logic rd_too, output logic [4:0] oe);
      int n;
      n = 0;
      while (ready_i !== 1'b1 && n < 100) begin
         @(posedge clk_sys_i);
         n++;
      end
      @(posedge clk_sys_i);
      sel_n_o <= !sel_ok;
      sel_o <= 1'b1;
      host_oe <= 1'b1;
      host_data <= {24'h0, b};
      wr_n_o <= 1'b0;
      rd_n_o <= !rd_too;
      repeat (6) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      oe = bus_oe_n_i[7:3];
      @(posedge clk_sys_i);
      wr_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      host_oe <= 1'b0;
      sel_n_o <= 1'b1;
   endtask : wr_byte
   task automatic rd_status(output logic [7:0] st, output logic [4:0] oe);
      @(posedge clk_sys_i);
      sel_n_o <= 1'b0;
      sel_o <= 1'b1;
      rd_n_o <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      st = bus_o[7:0];
      oe = bus_oe_n_i[7:3];
      @(posedge clk_sys_i);
      rd_n_o <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      sel_n_o <= 1'b1;
   endtask : rd_status
   task automatic xfer(input logic dir, input logic [17:0] a, input logic [1:0] sz, input logic bst,
                       input logic [31:0] wd, output logic [31:0] rd, output logic ok);
      int n;
      ok = 1'b0;
      rd = 32'h0;
      @(posedge clk_sys_i);
      sel_n_o <= 1'b0;
      sel_o <= 1'b1;
      wr_n_o <= dir;
      addr_o <= a;
      tsz_o <= sz;
      burst_n_o <= !bst;
      host_oe <= !dir;
      host_data <= wd;
      rd_n_o <= 1'b0;
      @(posedge clk_sys_i);
      rd_n_o <= 1'b1;
      n = 0;
      while (!ok && n < 40) begin
         @(negedge clk_sys_i);
         if (ack_n_i === 1'b0) begin
            ok = 1'b1;
            rd = bus_o;
         end
         n++;
      end
      @(posedge clk_sys_i);
      host_oe <= 1'b0;
      sel_n_o <= 1'b1;
      wr_n_o <= 1'b1;
   endtask : xfer
endmodule : chp_host_model
